/* hdl/usb_function_mask_and_control_cfg.svh */
// Offsets, field positions, reset values and timing of the function mask/control bank.
`ifndef USB_FUNCTION_MASK_AND_CONTROL_CFG_SVH
`define USB_FUNCTION_MASK_AND_CONTROL_CFG_SVH

// Byte addresses on the register bus.
`define UFC_OFS_FLAGS        8'h00
`define UFC_OFS_MASK         8'h04
`define UFC_OFS_CTL          8'h08

// Event flag and mask bit positions.
`define UFC_EV_SETUP_OVR     0
`define UFC_EV_RSV           1
`define UFC_EV_SETUP_RCV     2
`define UFC_EV_PWR_UP        3
`define UFC_EV_PWR_DOWN      4
`define UFC_EV_RESUME        5
`define UFC_EV_SUSPEND       6
`define UFC_EV_BUS_RESET     7

// Control bit positions.
`define UFC_CTL_DIR          0
`define UFC_CTL_SETUP_SVC    1
`define UFC_CTL_SELF_PWR     2
`define UFC_CTL_WAKE_PERMIT  3
`define UFC_CTL_COUPLING     4
`define UFC_CTL_WAKE_REQ     5
`define UFC_CTL_HUB_GEN      6
`define UFC_CTL_ATTACH       7

// Reset values and implemented-bit masks.
`define UFC_FLAGS_RST        8'h00
`define UFC_MASK_RST         8'h00
`define UFC_CTL_RST          8'h10
`define UFC_EV_VALID         8'hFD
`define UFC_READ_NONE        32'h0000_0000

// Length of the remote wake-up pulse in clock cycles.
`define UFC_WAKE_PULSE_CYC   1

`endif

/* hdl/usb_function_mask_and_control_pkg.sv */
// Types shared by the function mask/control bank.
package usb_function_mask_and_control_pkg;

    // Register selected by a bus address.
    typedef enum logic [1:0] {
        SEL_FLAGS,
        SEL_MASK,
        SEL_CTL,
        SEL_NONE
    } reg_sel_t;

    typedef logic [7:0] byte_t;

endpackage

/* hdl/usb_function_mask_and_control.sv */
// Event flags, interrupt enable mask and control register of the embedded USB function.
//
// The register offsets and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
`include "usb_function_mask_and_control_cfg.svh"

// Function
// [R1] Mask bits 0,2,3,4 enable setup-overrun, setup, power-up, power-down interrupts; reset 0.
// [R2] Mask bit 5 enables the resume interrupt; resets to 0.
// [R3] Mask bit 6 enables the suspend interrupt; resets to 0.
// [R4] Mask bit 7 enables the bus-reset interrupt; resets to 0.
// [R5] Control register clears only on power-up reset, never on USB reset.
// [R6] Control bit 0 gives data stage direction: 0 OUT, 1 IN.
// [R7] Control bit 1 tells hardware that setup servicing is in progress.
// [R8] Control bit 2 reports power source: 0 bus, 1 self powered.
// [R9] Firmware sets control bit 3 on remote wake-up feature set, clears on clear.
// [R10] Control bit 4, reset 1, couples function reset into controller reset.
// [R11] Writing 1 to control bit 5 emits a wake-up pulse; bit self-clears.
// [R12] Control bit 6 selects hub generation: 0 is 1.x, 1 is 2.x.
// [R13] Control bit 7 enables upstream pullup (attached); 0 detaches.
// [R14] A status flag interrupts only while its mask bit is set.
// [R15] Hardware sets flags; writing 1 clears, writing 0 leaves them.
// [R16] Mask bit 1 reads 0, ignores writes; interrupt ORs enabled pending flags.
module usb_function_mask_and_control
    import usb_function_mask_and_control_pkg::*;
(
    // Clock and power-up reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // USB engine events, one-cycle pulses on clk_i
    input  wire logic        setup_overrun_evt_i,
    input  wire logic        setup_rcvd_evt_i,
    input  wire logic        port3_power_up_evt_i,
    input  wire logic        port3_power_down_evt_i,
    input  wire logic        resume_evt_i,
    input  wire logic        suspend_evt_i,
    input  wire logic        bus_reset_evt_i,
    // USB function reset level from the USB engine
    input  wire logic        usb_func_reset_i,
    // Interrupt and control outputs
    output logic             irq_o,
    output logic             data_dir_in_o,
    output logic             setup_service_active_o,
    output logic             self_powered_o,
    output logic             wakeup_permit_o,
    output logic             mcu_reset_o,
    output logic             wakeup_pulse_o,
    output logic             hub_generation_sel_o,
    output logic             upstream_attach_o
);

    // Address decode shared by the read and write paths.
    function automatic reg_sel_t decode(input logic [7:0] adr);
        reg_sel_t sel;
        sel = SEL_NONE;
        if (adr == `UFC_OFS_FLAGS) begin
            sel = SEL_FLAGS;
        end else if (adr == `UFC_OFS_MASK) begin
            sel = SEL_MASK;
        end else if (adr == `UFC_OFS_CTL) begin
            sel = SEL_CTL;
        end
        return sel;
    endfunction

    byte_t    usb_event_flags_ff;
    byte_t    usb_event_enable_mask_ff;
    byte_t    usb_function_control_ff;
    byte_t    evt_vec;
    byte_t    wr_byte;
    reg_sel_t cur_sel;
    logic     ack_ff;
    logic     req;
    logic     wr_go;
    logic     wr_flags;
    logic     wr_mask;
    logic     wr_ctl;
    logic     mcu_reset_ff;
    logic     wake_pulse_ff;

    assign req      = wb_cyc_i & wb_stb_i;
    assign cur_sel  = decode(wb_adr_i);
    assign wr_byte  = wb_dat_i[7:0];
    // Writes land on the edge where the master sees ack, and only with lane 0 enabled.
    assign wr_go    = req & ack_ff & wb_we_i & wb_sel_i[0];
    assign wr_flags = wr_go & (cur_sel == SEL_FLAGS);
    assign wr_mask  = wr_go & (cur_sel == SEL_MASK);
    assign wr_ctl   = wr_go & (cur_sel == SEL_CTL);

    // Bus answer: ack one cycle after the request is seen, then dropped for a cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req & ~ack_ff;
        end
    end
    assign wb_ack_o = ack_ff;

    // Read data is captured with the ack so it is stable while ack is high.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= `UFC_READ_NONE;
        end else if (req & ~ack_ff) begin
            if (cur_sel == SEL_FLAGS) begin
                wb_dat_o <= {24'h000000, usb_event_flags_ff};
            end else if (cur_sel == SEL_MASK) begin
                wb_dat_o <= {24'h000000, usb_event_enable_mask_ff};
            end else if (cur_sel == SEL_CTL) begin
                wb_dat_o <= {24'h000000, usb_function_control_ff};
            end else begin
                wb_dat_o <= `UFC_READ_NONE;
            end
        end
    end

    always_comb begin
        evt_vec                     = 8'h00;
        evt_vec[`UFC_EV_SETUP_OVR]  = setup_overrun_evt_i;
        evt_vec[`UFC_EV_SETUP_RCV]  = setup_rcvd_evt_i;
        evt_vec[`UFC_EV_PWR_UP]     = port3_power_up_evt_i;
        evt_vec[`UFC_EV_PWR_DOWN]   = port3_power_down_evt_i;
        evt_vec[`UFC_EV_RESUME]     = resume_evt_i;
        evt_vec[`UFC_EV_SUSPEND]    = suspend_evt_i;
        evt_vec[`UFC_EV_BUS_RESET]  = bus_reset_evt_i;
    end

    // Sticky flags; a new event in the clearing cycle wins over the clear.
    // The bus-reset flag survives a function reset so firmware can see its cause.
    // Power-up flag value kept as a vector so that each generated bit can pick its own.
    localparam byte_t FLAGS_RST = `UFC_FLAGS_RST;
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_flag
            if (gi == `UFC_EV_RSV) begin : g_rsv
                always_ff @(posedge clk_i) begin
                    usb_event_flags_ff[gi] <= 1'b0;
                end
            end else begin : g_live
                always_ff @(posedge clk_i) begin
                    if (rst_i) begin
                        usb_event_flags_ff[gi] <= FLAGS_RST[gi];
                    end else if (evt_vec[gi]) begin
                        usb_event_flags_ff[gi] <= 1'b1; // R15
                    end else if (usb_func_reset_i && gi != `UFC_EV_BUS_RESET) begin
                        usb_event_flags_ff[gi] <= 1'b0;
                    end else if (wr_flags && wr_byte[gi]) begin
                        usb_event_flags_ff[gi] <= 1'b0; // R15
                    end
                end
            end
        end
    endgenerate

    // Mask is cleared by either reset; the reserved bit never stores.
    always_ff @(posedge clk_i) begin
        if (rst_i || usb_func_reset_i) begin
            usb_event_enable_mask_ff <= `UFC_MASK_RST; // R1 R2 R3 R4
        end else if (wr_mask) begin
            usb_event_enable_mask_ff <= wr_byte & `UFC_EV_VALID; // R1 R2 R3 R4 R16
        end
    end

    // Interrupt is the OR of enabled pending flags.
    assign irq_o = |(usb_event_flags_ff & usb_event_enable_mask_ff); // R14 R16

    // Control ignores the USB function reset on purpose: attach and coupling must
    // outlive a bus reset or the device would drop off the bus.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            usb_function_control_ff <= `UFC_CTL_RST; // R5 R10
        end else if (wr_ctl) begin
            usb_function_control_ff <= wr_byte; // R6 R7 R8 R12 R13
        end else begin
            usb_function_control_ff[`UFC_CTL_WAKE_REQ] <= 1'b0; // R11
        end
    end

    // Wake-up pulse lasts exactly as long as the request bit stays set.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_pulse_ff <= 1'b0;
        end else begin
            wake_pulse_ff <= wr_ctl & wr_byte[`UFC_CTL_WAKE_REQ]; // R11
        end
    end
    assign wakeup_pulse_o = wake_pulse_ff;

    // Controller reset follows the function reset only while coupling is on.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mcu_reset_ff <= 1'b0;
        end else begin
            mcu_reset_ff <= usb_func_reset_i
                            & usb_function_control_ff[`UFC_CTL_COUPLING]; // R10
        end
    end
    assign mcu_reset_o = mcu_reset_ff;

    assign data_dir_in_o          = usb_function_control_ff[`UFC_CTL_DIR];         // R6
    assign setup_service_active_o = usb_function_control_ff[`UFC_CTL_SETUP_SVC];   // R7
    assign self_powered_o         = usb_function_control_ff[`UFC_CTL_SELF_PWR];    // R8
    assign wakeup_permit_o        = usb_function_control_ff[`UFC_CTL_WAKE_PERMIT]; // R9
    assign hub_generation_sel_o   = usb_function_control_ff[`UFC_CTL_HUB_GEN];     // R12
    assign upstream_attach_o      = usb_function_control_ff[`UFC_CTL_ATTACH];      // R13

    // Checks.
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_wr_mask;
        wr_mask;
    endsequence

    sequence s_wr_ctl;
        wr_ctl && !usb_func_reset_i;
    endsequence

    sequence s_wake_req;
        wr_ctl && wr_byte[`UFC_CTL_WAKE_REQ];
    endsequence

    sequence s_pulse_once;
        wakeup_pulse_o ##1 !wakeup_pulse_o;
    endsequence

    chk_mask_store: assert property ( // R1
        s_wr_mask |=> usb_event_enable_mask_ff == ($past(wr_byte) & `UFC_EV_VALID))
        else $error("mask write not stored");

    chk_mask_rsv: assert property ( // R16
        usb_event_enable_mask_ff[`UFC_EV_RSV] == 1'b0 && !usb_event_flags_ff[`UFC_EV_RSV])
        else $error("reserved bit not zero");

    chk_resume_gate: assert property ( // R2
        resume_evt_i && usb_event_enable_mask_ff[`UFC_EV_RESUME] && !wr_mask
            && !usb_func_reset_i |=> irq_o)
        else $error("enabled resume did not interrupt");

    chk_suspend_gate: assert property ( // R3
        (usb_event_flags_ff == (8'h01 << `UFC_EV_SUSPEND))
            && !usb_event_enable_mask_ff[`UFC_EV_SUSPEND] |-> !irq_o)
        else $error("masked suspend interrupted");

    chk_busrst_keep: assert property ( // R4
        bus_reset_evt_i ##1 (usb_func_reset_i && !wr_flags)[*2]
            |-> usb_event_flags_ff[`UFC_EV_BUS_RESET])
        else $error("bus reset flag lost on function reset");

    chk_ctl_hold: assert property ( // R5
        usb_func_reset_i && !wr_ctl
            |=> usb_function_control_ff[7:6] == $past(usb_function_control_ff[7:6])
                && usb_function_control_ff[4:0] == $past(usb_function_control_ff[4:0]))
        else $error("control changed on function reset");

    chk_attach_wr: assert property ( // R13
        s_wr_ctl |=> upstream_attach_o == $past(wr_byte[`UFC_CTL_ATTACH])
            && data_dir_in_o == $past(wr_byte[`UFC_CTL_DIR]))
        else $error("control write not reflected");

    chk_coupling: assert property ( // R10
        usb_func_reset_i && usb_function_control_ff[`UFC_CTL_COUPLING] |=> mcu_reset_o)
        else $error("coupled reset not passed");

    chk_isolate: assert property ( // R10
        !usb_function_control_ff[`UFC_CTL_COUPLING] && !wr_ctl |=> !mcu_reset_o)
        else $error("isolated reset leaked");

    chk_wake_pulse: assert property ( // R11
        s_wake_req |=> s_pulse_once ##0 !usb_function_control_ff[`UFC_CTL_WAKE_REQ])
        else $error("wake pulse wrong");

    chk_flag_set: assert property ( // R15
        setup_rcvd_evt_i |=> usb_event_flags_ff[`UFC_EV_SETUP_RCV])
        else $error("event flag not set");

    chk_flag_wzero: assert property ( // R15
        usb_event_flags_ff[`UFC_EV_PWR_UP] && wr_flags && !wr_byte[`UFC_EV_PWR_UP]
            && !usb_func_reset_i |=> usb_event_flags_ff[`UFC_EV_PWR_UP])
        else $error("write zero cleared flag");

    chk_flag_clear: assert property ( // R15
        wr_flags && wr_byte[`UFC_EV_PWR_DOWN] && !port3_power_down_evt_i
            |=> !usb_event_flags_ff[`UFC_EV_PWR_DOWN])
        else $error("write one did not clear");

    chk_sel_drop: assert property (
        req && ack_ff && wb_we_i && !wb_sel_i[0] && !usb_func_reset_i
            |=> usb_event_enable_mask_ff == $past(usb_event_enable_mask_ff))
        else $error("write without lane 0 stored");

    chk_ack_once: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");

endmodule

/* verification/usb_event_source.sv */
// Model of the USB engine that raises single-cycle event pulses toward the bank.
`timescale 1ns/1ps
module usb_event_source
    import usb_function_mask_and_control_pkg::*;
(
    // Clock
    input  wire logic  clk_i,
    // Event request, one bit per flag position
    input  wire byte_t evt_req_i,
    // Event pulses toward the bank
    output logic       setup_overrun_o,
    output logic       setup_rcvd_o,
    output logic       power_up_o,
    output logic       power_down_o,
    output logic       resume_o,
    output logic       suspend_o,
    output logic       bus_reset_o
);
    byte_t pulse_ff;

    // The engine never reports on the reserved position, so bit 1 is dropped here.
    always_ff @(posedge clk_i) begin
        pulse_ff <= evt_req_i & 8'hFD;
    end

    assign setup_overrun_o = pulse_ff[0];
    assign setup_rcvd_o    = pulse_ff[2];
    assign power_up_o      = pulse_ff[3];
    assign power_down_o    = pulse_ff[4];
    assign resume_o        = pulse_ff[5];
    assign suspend_o       = pulse_ff[6];
    assign bus_reset_o     = pulse_ff[7];
endmodule

/* verification/usb_function_mask_and_control_bench.sv */
// Self-checking bench for the function mask and control bank.
`timescale 1ns/1ps
`include "usb_function_mask_and_control_cfg.svh"
module usb_function_mask_and_control_bench
    import usb_function_mask_and_control_pkg::*;
;
    logic        clk_i   = 1'b0;
    logic        rst_i   = 1'b1;
    logic        cyc     = 1'b0;
    logic [3:0]  sel     = 4'h1;
    logic [3:0]  lanes   = 4'h1;
    logic        we      = 1'b0;
    logic [7:0]  adr     = 8'h00;
    logic [31:0] wdat    = 32'h0000_0000;
    byte_t       evt_req = 8'h00;
    logic        fres    = 1'b0;
    logic [31:0] rdat;
    logic        ack;
    logic [6:0]  ev;
    logic        irq, dir, svc, selfp, permit, mcu_rst, wake, hubg, attach;
    int          err_total = 0;
    int          checked   = 0;

    always #2.5 clk_i = ~clk_i;

    usb_event_source u_src (.clk_i(clk_i), .evt_req_i(evt_req), .setup_overrun_o(ev[0]),
        .setup_rcvd_o(ev[1]), .power_up_o(ev[2]), .power_down_o(ev[3]), .resume_o(ev[4]),
        .suspend_o(ev[5]), .bus_reset_o(ev[6]));

    usb_function_mask_and_control u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .setup_overrun_evt_i(ev[0]),
        .setup_rcvd_evt_i(ev[1]), .port3_power_up_evt_i(ev[2]),
        .port3_power_down_evt_i(ev[3]), .resume_evt_i(ev[4]), .suspend_evt_i(ev[5]),
        .bus_reset_evt_i(ev[6]), .usb_func_reset_i(fres), .irq_o(irq),
        .data_dir_in_o(dir), .setup_service_active_o(svc), .self_powered_o(selfp),
        .wakeup_permit_o(permit), .mcu_reset_o(mcu_rst), .wakeup_pulse_o(wake),
        .hub_generation_sel_o(hubg), .upstream_attach_o(attach));

    task automatic chk_reg(input byte_t g, input byte_t e);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED at %0t: value %h expected %h", $time, g, e);
        end
    endtask

    task automatic chk_pin(input logic g, input logic e);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED at %0t: pin %b expected %b", $time, g, e);
        end
    endtask

    // Leading edge wait keeps cyc low for a full cycle between two transfers.
    task automatic wb(input logic w, input logic [7:0] a, input byte_t d, output byte_t q);
        @(posedge clk_i);
        cyc  <= 1'b1;
        sel  <= lanes;
        we   <= w;
        adr  <= a;
        wdat <= {24'h00_0000, d};
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        q = rdat[7:0];
        cyc <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input byte_t d);
        byte_t q;
        wb(1'b1, a, d, q);
        #1;
    endtask

    task automatic rd_chk(input logic [7:0] a, input byte_t e);
        byte_t q;
        wb(1'b0, a, 8'h00, q);
        chk_reg(q, e);
    endtask

    task automatic fire(input byte_t b);
        @(posedge clk_i);
        evt_req <= b;
        @(posedge clk_i);
        evt_req <= 8'h00;
        repeat (2) @(posedge clk_i);
        #1;
    endtask

    task automatic t_reset();
        rd_chk(`UFC_OFS_FLAGS, 8'h00);
        rd_chk(`UFC_OFS_MASK, 8'h00);
        rd_chk(`UFC_OFS_CTL, 8'h10);
        chk_pin(irq, 1'b0);
        rd_chk(8'h0C, 8'h00);
        lanes = 4'hE;
        wr(`UFC_OFS_MASK, 8'hFF);
        lanes = 4'h1;
        rd_chk(`UFC_OFS_MASK, 8'h00);
        wr(`UFC_OFS_MASK, 8'hFF);
        rd_chk(`UFC_OFS_MASK, 8'hFD);
        wr(`UFC_OFS_MASK, 8'h00);
        $display("test reset and mask done");
    endtask

    task automatic t_events();
        byte_t b;
        for (int i = 0; i < 8; i++) begin
            if (i == 1) continue;
            b = 8'h01 << i;
            fire(b);
            chk_pin(irq, 1'b0);
            rd_chk(`UFC_OFS_FLAGS, b);
            wr(`UFC_OFS_MASK, b);
            chk_pin(irq, 1'b1);
            wr(`UFC_OFS_FLAGS, ~b);
            rd_chk(`UFC_OFS_FLAGS, b);
            wr(`UFC_OFS_FLAGS, b);
            chk_pin(irq, 1'b0);
            wr(`UFC_OFS_MASK, 8'h00);
        end
        fire(8'hFD);
        wr(`UFC_OFS_MASK, 8'h02);
        chk_pin(irq, 1'b0);
        wr(`UFC_OFS_FLAGS, 8'hFF);
        rd_chk(`UFC_OFS_FLAGS, 8'h00);
        $display("test events done");
    endtask

    // A walking one over bits 0-3, 6 and 7 shows each of them reaching only its own pin.
    task automatic t_ctl();
        byte_t v[8] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h40, 8'h80, 8'hDF, 8'h10};
        foreach (v[i]) begin
            wr(`UFC_OFS_CTL, v[i]);
            chk_reg({attach, hubg, 2'b00, permit, selfp, svc, dir}, v[i] & 8'hCF);
            rd_chk(`UFC_OFS_CTL, v[i] & 8'hDF);
        end
        wr(`UFC_OFS_CTL, 8'h30);
        chk_pin(wake, 1'b1);
        @(posedge clk_i);
        #1;
        chk_pin(wake, 1'b0);
        rd_chk(`UFC_OFS_CTL, 8'h10);
        $display("test control done");
    endtask

    task automatic t_func_reset();
        wr(`UFC_OFS_CTL, 8'h94);
        wr(`UFC_OFS_MASK, 8'hFD);
        fire(8'hFD);
        chk_pin(irq, 1'b1);
        @(posedge clk_i);
        evt_req <= 8'h80;
        @(posedge clk_i);
        evt_req <= 8'h00;
        fres    <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk_pin(mcu_rst, 1'b1);
        fres <= 1'b0;
        rd_chk(`UFC_OFS_CTL, 8'h94);
        rd_chk(`UFC_OFS_MASK, 8'h00);
        rd_chk(`UFC_OFS_FLAGS, 8'h80);
        wr(`UFC_OFS_CTL, 8'h84);
        @(posedge clk_i);
        fres <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk_pin(mcu_rst, 1'b0);
        fres  <= 1'b0;
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk(`UFC_OFS_CTL, 8'h10);
        rd_chk(`UFC_OFS_FLAGS, 8'h00);
        $display("test resets done");
    endtask

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_events();
        t_ctl();
        t_func_reset();
        give_verdict();
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        give_verdict();
    end
endmodule
